// [hdl/jio_core.sv]
`timescale 1ns/100ps
`default_nettype none
`include "jio_params.svh"

// What this block does
// [RULE1] jump loads its 11-bit immediate into pointer bits 10..0.
// [RULE2] jump fills pointer bits 12..11 from upper jump latch bits 4..3.
// [RULE3] jump is unconditional, takes two cycles, touches no status flag.
// [RULE4] bump-and-skip adds one to file register, result to acc or file by dest bit.
// [RULE5] nonzero bump-and-skip result: next instruction runs, flags unchanged.
// [RULE6] zero bump-and-skip result: following instruction becomes idle op, two cycles.
// [RULE7] or-literal ORs acc with 8-bit immediate into acc.
// [RULE8] or-literal updates only the result-null flag.
// [RULE9] or-file ORs acc with file register, result to acc or file by dest bit.
// [RULE10] or-file updates result-null flag; file addresses span 0 to 127.
// [RULE11] plain bump adds one, routes by dest bit, updates result-null, never skips.
// [RULE12] increments wrap modulo 256; plain bump sets result-null exactly when result is zero.
module jio_core (
    input  wire logic                          clock,
    input  wire logic                          rst,
    input  wire jio_pkg::jio_instr_t           instr,
    input  wire logic [7:0]                    upper_jump_latch,
    input  wire logic [7:0]                    file_rdata,
    output logic      [`JIO_FILE_ADDR_W-1:0]   file_raddr,
    output jio_pkg::jio_file_wr_t              file_wr,
    output logic      [`JIO_IP_W-1:0]          instruction_pointer,
    output logic      [7:0]                    acc,
    output logic                               result_null,
    output logic                               slot_discarded
);

    logic [`JIO_IP_W-1:0]        ip_q;
    logic [7:0]                  acc_q;
    logic                        null_q;
    logic                        squash_q;
    jio_pkg::jio_squash_kind_t   squash_kind_q;
    jio_pkg::jio_file_wr_t       wr_q;

    logic                        exec;
    logic                        is_jump;
    logic                        is_bump_skip;
    logic                        is_or_lit;
    logic                        is_or_file;
    logic                        is_bump;
    logic                        dest_file;
    logic [`JIO_FILE_ADDR_W-1:0] faddr;
    logic [7:0]                  fdat;
    logic [7:0]                  sum;
    logic [7:0]                  or_file_res;
    logic [7:0]                  or_lit_res;
    logic [7:0]                  alu_res;
    logic                        writes_result;
    logic                        sets_null;
    logic                        skip_next;
    logic [`JIO_IP_W-1:0]        jump_target;

    // decode; a discarded slot executes as idle op
    assign exec         = instr.valid & ~squash_q;
    assign is_jump      = instr.word[13:11] == `JIO_OPC_JUMP;
    assign is_bump_skip = instr.word[13:8] == `JIO_OPC_BUMP_SKIP;
    assign is_or_lit    = instr.word[13:8] == `JIO_OPC_OR_LIT;
    assign is_or_file   = instr.word[13:8] == `JIO_OPC_OR_FILE;
    assign is_bump      = instr.word[13:8] == `JIO_OPC_BUMP;
    assign dest_file    = instr.word[`JIO_DEST_BIT];
    assign faddr        = instr.word[`JIO_FILE_ADDR_W-1:0]; // see [RULE10]

    // forward a write still in flight so back-to-back file ops see it
    assign fdat = (wr_q.we && wr_q.addr == faddr) ? wr_q.data : file_rdata;

    assign sum         = fdat + `JIO_ONE; // see [RULE12]
    assign or_file_res = acc_q | fdat; // see [RULE9]
    assign or_lit_res  = acc_q | instr.word[7:0]; // see [RULE7]

    always_comb begin
        alu_res       = `JIO_ZERO;
        writes_result = 1'b0;
        sets_null     = 1'b0;
        if (is_bump_skip) begin
            alu_res       = sum; // see [RULE4]
            writes_result = 1'b1;
        end else if (is_bump) begin
            alu_res       = sum; // see [RULE11]
            writes_result = 1'b1;
            sets_null     = 1'b1;
        end else if (is_or_file) begin
            alu_res       = or_file_res;
            writes_result = 1'b1;
            sets_null     = 1'b1; // see [RULE10]
        end else if (is_or_lit) begin
            alu_res       = or_lit_res;
            writes_result = 1'b1;
            sets_null     = 1'b1; // see [RULE8]
        end
    end

    assign skip_next   = is_bump_skip && sum == `JIO_ZERO; // see [RULE6]
    assign jump_target = {upper_jump_latch[`JIO_LATCH_HI:`JIO_LATCH_LO], // see [RULE2]
                          instr.word[`JIO_JUMP_K_W-1:0]}; // see [RULE1]

    // instruction pointer
    always_ff @(posedge clock) begin
        if (rst) begin
            ip_q <= `JIO_IP_RST;
        end else if (instr.valid) begin
            if (squash_q) begin
                if (squash_kind_q == jio_pkg::JIO_SQ_ADVANCE) begin
                    ip_q <= ip_q + `JIO_IP_W'(1);
                end
            end else if (is_jump) begin
                ip_q <= jump_target; // see [RULE1] see [RULE2]
            end else begin
                ip_q <= ip_q + `JIO_IP_W'(1);
            end
        end
    end

    // discard of the slot after a jump or a zero skip
    always_ff @(posedge clock) begin
        if (rst) begin
            squash_q      <= 1'b0;
            squash_kind_q <= jio_pkg::JIO_SQ_ADVANCE;
        end else if (instr.valid) begin
            squash_q      <= exec & (is_jump | skip_next); // see [RULE3] see [RULE6]
            squash_kind_q <= is_jump ? jio_pkg::JIO_SQ_HOLD : jio_pkg::JIO_SQ_ADVANCE;
        end
    end

    // accumulator
    always_ff @(posedge clock) begin
        if (rst) begin
            acc_q <= `JIO_ACC_RST;
        end else if (exec && writes_result && (is_or_lit || !dest_file)) begin
            acc_q <= alu_res; // see [RULE4] see [RULE7] see [RULE9] see [RULE11]
        end
    end

    // result-null flag; jump and bump-and-skip leave it alone
    always_ff @(posedge clock) begin
        if (rst) begin
            null_q <= 1'b0;
        end else if (exec && sets_null) begin
            null_q <= alu_res == `JIO_ZERO; // see [RULE12] see [RULE8] see [RULE10]
        end
    end

    // registered file write port
    always_ff @(posedge clock) begin
        if (rst) begin
            wr_q <= '0;
        end else begin
            wr_q.we   <= exec && writes_result && !is_or_lit && dest_file;
            wr_q.addr <= faddr;
            wr_q.data <= alu_res; // see [RULE4] see [RULE9] see [RULE11]
        end
    end

    assign file_raddr          = faddr;
    assign file_wr             = wr_q;
    assign instruction_pointer = ip_q;
    assign acc                 = acc_q;
    assign result_null         = null_q;
    assign slot_discarded      = squash_q;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence s_jump;
        exec && is_jump;
    endsequence

    sequence s_zero_skip;
        exec && skip_next;
    endsequence

    sequence s_nonzero_skip;
        exec && is_bump_skip && sum != `JIO_ZERO;
    endsequence

    AST_JUMP_LOW: assert property (s_jump |=> // see [RULE1]
        ip_q[`JIO_JUMP_K_W-1:0] == $past(instr.word[`JIO_JUMP_K_W-1:0]))
        else $error("jump low pointer bits wrong");

    AST_JUMP_HIGH: assert property (s_jump |=> // see [RULE2]
        ip_q[12:11] == $past(upper_jump_latch[`JIO_LATCH_HI:`JIO_LATCH_LO]))
        else $error("jump high pointer bits wrong");

    AST_JUMP_TWO_CYCLE: assert property (s_jump ##1 instr.valid |=> // see [RULE3]
        ip_q == $past(ip_q) && null_q == $past(null_q, 2) && !wr_q.we)
        else $error("jump second cycle not idle");

    AST_BUMP_SKIP_ACC: assert property (exec && is_bump_skip && !dest_file |=> // see [RULE4]
        acc_q == $past(sum))
        else $error("bump-and-skip acc result wrong");

    AST_NONZERO_SKIP: assert property (s_nonzero_skip |=> // see [RULE5]
        !squash_q && null_q == $past(null_q))
        else $error("nonzero bump-and-skip misbehaved");

    AST_ZERO_SKIP: assert property (s_zero_skip ##1 instr.valid |=> // see [RULE6]
        squash_q == 1'b0 && acc_q == $past(acc_q) && ip_q == $past(ip_q) + `JIO_IP_W'(1))
        else $error("skipped slot not idle");

    AST_OR_LIT: assert property (exec && is_or_lit |=> // see [RULE7]
        acc_q == ($past(acc_q) | $past(instr.word[7:0])) && !wr_q.we)
        else $error("or-literal result wrong");

    AST_OR_LIT_NULL: assert property (exec && is_or_lit |=> // see [RULE8]
        null_q == (acc_q == `JIO_ZERO))
        else $error("or-literal null flag wrong");

    AST_OR_FILE_WR: assert property (exec && is_or_file && dest_file |=> // see [RULE9]
        wr_q.we && wr_q.data == $past(or_file_res) && acc_q == $past(acc_q))
        else $error("or-file write wrong");

    AST_OR_FILE_NULL: assert property (exec && is_or_file |=> // see [RULE10]
        null_q == ($past(or_file_res) == `JIO_ZERO))
        else $error("or-file null flag wrong");

    AST_BUMP_PLAIN: assert property (exec && is_bump |=> // see [RULE11]
        !squash_q && null_q == ($past(sum) == `JIO_ZERO))
        else $error("plain bump wrong");

    AST_WRAP: assert property (exec && is_bump && !dest_file && fdat == 8'hff |=> // see [RULE12]
        acc_q == `JIO_ZERO && null_q)
        else $error("increment did not wrap");

endmodule : jio_core

`default_nettype wire

// [hdl/jio_params.svh]
`ifndef JIO_PARAMS_SVH
`define JIO_PARAMS_SVH

// instruction word layout
`define JIO_WORD_W        14
`define JIO_IP_W          13
`define JIO_FILE_ADDR_W   7
`define JIO_DEST_BIT      7
`define JIO_JUMP_K_W      11
`define JIO_LATCH_HI      4
`define JIO_LATCH_LO      3

// opcode fields: jump uses bits 13:11, the others bits 13:8
`define JIO_OPC_JUMP      3'h5
`define JIO_OPC_BUMP_SKIP 6'h0f
`define JIO_OPC_OR_LIT    6'h38
`define JIO_OPC_OR_FILE   6'h04
`define JIO_OPC_BUMP      6'h0a

// reset values, then the one and zero constants
`define JIO_IP_RST        13'h0000
`define JIO_ACC_RST       8'h00
`define JIO_ONE           8'h01
`define JIO_ZERO          8'h00

`endif

// [hdl/jio_pkg.sv]
`include "jio_params.svh"

package jio_pkg;

    // fetched instruction presented to the core
    typedef struct packed {
        logic                         valid;
        logic [`JIO_WORD_W-1:0]       word;
    } jio_instr_t;

    // registered write port into the file register space
    typedef struct packed {
        logic                         we;
        logic [`JIO_FILE_ADDR_W-1:0]  addr;
        logic [7:0]                   data;
    } jio_file_wr_t;

    // what the discarded slot after a two-cycle instruction does to the pointer
    typedef enum logic {
        JIO_SQ_ADVANCE,
        JIO_SQ_HOLD
    } jio_squash_kind_t;

endpackage : jio_pkg

// [bench/jio_testbench.sv]
`timescale 1ns/100ps
`default_nettype none
`include "jio_params.svh"

module testbench;
    logic                         clock;
    logic                         rst;
    jio_pkg::jio_instr_t          instr;
    logic [7:0]                   upper_jump_latch;
    logic [7:0]                   file_rdata;
    logic [`JIO_FILE_ADDR_W-1:0]  file_raddr;
    jio_pkg::jio_file_wr_t        file_wr;
    logic [`JIO_IP_W-1:0]         instruction_pointer;
    logic [7:0]                   acc;
    logic                         result_null;
    logic                         slot_discarded;
    int                           err_count;
    int                           checks;
    logic [`JIO_IP_W-1:0]         ip0;

    jio_core uut (
        .clock               (clock),
        .rst                 (rst),
        .instr               (instr),
        .upper_jump_latch    (upper_jump_latch),
        .file_rdata          (file_rdata),
        .file_raddr          (file_raddr),
        .file_wr             (file_wr),
        .instruction_pointer (instruction_pointer),
        .acc                 (acc),
        .result_null         (result_null),
        .slot_discarded      (slot_discarded)
    );

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    task automatic conclude();
        $display("checks %0d, errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : conclude

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    function automatic logic [`JIO_WORD_W-1:0] op(input logic [5:0] opc, input logic d,
                                                  input logic [6:0] a);
        return {opc, d, a};
    endfunction : op

    // presents one word at a falling edge, returns one cycle later
    task automatic step(input logic [`JIO_WORD_W-1:0] w, input logic [7:0] f);
        instr      = '{valid: 1'b1, word: w};
        file_rdata = f;
        #1;
        chk(16'(file_raddr), 16'(w[6:0]), "read address");
        @(negedge clock);
    endtask : step

    task automatic t_or_lit();
        step({`JIO_OPC_OR_LIT, 8'h00}, 8'h00);
        chk(16'({acc, result_null}), 16'h0001, "or literal zero");
        step({`JIO_OPC_OR_LIT, 8'ha5}, 8'h00);
        chk(16'({acc, result_null}), 16'h014a, "or literal");
        chk(16'({file_wr.we, instruction_pointer}), 16'h0002, "no write");
    endtask : t_or_lit

    task automatic t_or_file();
        step(op(`JIO_OPC_OR_FILE, 1'b0, 7'h00), 8'h18);
        chk(16'({acc, result_null}), 16'h017a, "or file into acc");
        step(op(`JIO_OPC_OR_FILE, 1'b1, 7'h7f), 8'h02);
        chk(16'(file_wr), 16'hffbf, "or file into file");
        chk(16'(acc), 16'h00bd, "acc kept");
    endtask : t_or_file

    task automatic t_bump();
        step(op(`JIO_OPC_BUMP, 1'b1, 7'h22), 8'h41);
        chk(16'(file_wr), 16'ha242, "bump into file");
        chk(16'({acc, result_null}), 16'h017a, "bump file flags");
        step(op(`JIO_OPC_BUMP, 1'b0, 7'h11), 8'hff);
        chk(16'({acc, result_null, slot_discarded}), 16'h0002, "bump wrap");
    endtask : t_bump

    task automatic t_skip();
        step(op(`JIO_OPC_BUMP_SKIP, 1'b0, 7'h01), 8'h10);
        chk(16'({acc, result_null, slot_discarded}), 16'h0046, "skip nonzero");
        ip0 = instruction_pointer;
        step(op(`JIO_OPC_BUMP_SKIP, 1'b1, 7'h05), 8'hff);
        chk(16'(file_wr), 16'h8500, "skip zero write");
        chk(16'({result_null, slot_discarded}), 16'h0003, "skip zero");
        chk(16'(instruction_pointer), 16'(ip0 + 13'h0001), "skip pointer");
        step({`JIO_OPC_OR_LIT, 8'hff}, 8'h00);
        chk(16'({acc, slot_discarded, file_wr.we}), 16'h0044, "slot idle");
        chk(16'(instruction_pointer), 16'(ip0 + 13'h0002), "skip done");
    endtask : t_skip

    task automatic t_jump();
        upper_jump_latch = 8'he8;
        step({`JIO_OPC_JUMP, 11'h7ff}, 8'h00);
        chk(16'(instruction_pointer), 16'h0fff, "jump target");
        chk(16'({result_null, slot_discarded}), 16'h0003, "jump flags");
        instr.valid = 1'b0;
        @(negedge clock);
        chk(16'({instruction_pointer, slot_discarded}), 16'h1fff, "discard waits");
        step({`JIO_OPC_OR_LIT, 8'h0e}, 8'h00);
        chk(16'({acc, slot_discarded}), 16'h0022, "jump slot idle");
        chk(16'(instruction_pointer), 16'h0fff, "jump slot holds");
        upper_jump_latch = 8'h17;
        step({`JIO_OPC_JUMP, 11'h000}, 8'h00);
        chk(16'(instruction_pointer), 16'h1000, "jump high latch");
        step(op(`JIO_OPC_BUMP, 1'b0, 7'h00), 8'h00);
        step({`JIO_OPC_OR_LIT, 8'h00}, 8'h00);
        chk(16'({acc, result_null}), 16'h0022, "target runs");
        chk(16'(instruction_pointer), 16'h1001, "target pointer");
    endtask : t_jump

    initial begin
        #1000000;
        err_count++;
        conclude();
    end

    initial begin
        err_count = 0;
        checks = 0;
        rst = 1'b1;
        instr = '0;
        upper_jump_latch = 8'h00;
        file_rdata = 8'h00;
        repeat (20) @(negedge clock);
        chk(16'({instruction_pointer, result_null, slot_discarded}), 16'h0000, "reset state");
        chk(16'({acc, file_wr.we}), 16'h0000, "reset acc");
        rst = 1'b0;
        @(negedge clock);
        t_or_lit();
        t_or_file();
        t_bump();
        t_skip();
        t_jump();
        conclude();
    end
endmodule : testbench

`default_nettype wire
